// ===== common/branch_params.svh
// constants for the sign/overflow branch unit and its weight-to-stone converter
// assumes a byte-wide program memory and a 16-bit program counter
//
// How it works
// - jump_if_negative loads the pc with the target when sign is one
// - jump_if_positive loads the pc with the target when sign is zero
// - jump_on_overflow_set loads the pc with the target when overflow is one
// - jump_on_overflow_clear loads the pc with the target when overflow is zero
// - every jump exists as a 2-byte relative and a 3-byte absolute encoding
// - relative jumps take 3 core cycles, absolute jumps take 4
// - target comes from the operand: offset from the next instruction or full address
// - weight_to_stone takes only the first accumulator and overwrites it
// - input counts 100 mg units; result shows two stone digits then pounds
`ifndef BRANCH_PARAMS_SVH
`define BRANCH_PARAMS_SVH

`define PC_W          16
// opcode group: bits 7..3 select the conditional jump group, bits 2..1 the
// condition, bit 0 the absolute form
`define OPC_JUMP_GRP  5'h09
`define OPC_ABS_BIT   0
`define OPC_COND_LSB  1
`define COND_NEG      2'h0
`define COND_POS      2'h1
`define COND_OVS      2'h2
`define COND_OVC      2'h3
// weight_to_stone: bits 7..2 fixed, bits 1..0 select the accumulator
`define OPC_STONE_GRP 6'h14
`define ACCU_FIRST    2'h0

`define LEN_REL       16'h0002
`define LEN_ABS       16'h0003
`define OPERAND_OFS1  16'h0001
`define OPERAND_OFS2  16'h0002

// 100 mg units to pounds: pounds = units * LB_RECIP >> LB_SHIFT
`define LB_RECIP      12'hE73
`define LB_SHIFT      24
`define STONE_LB      4'hE
`define STONE_MAX     7'h63
`define LB_SAT        4'hD
`define DISP_SCALE    7'h64

`endif

// ===== common/branch_pkg.sv
// types shared by the branch unit and the stone converter
// assumes branch_params.svh is on the include path
package branch_pkg;
   `include "branch_params.svh"

   typedef struct packed {
      logic sign;
      logic overflow;
      logic carry;
      logic zero;
   } flags_t;

   typedef struct packed {
      logic             load;
      logic             taken;
      logic [`PC_W-1:0] value;
   } pc_update_t;

   typedef enum logic [2:0] {
      S_IDLE,
      S_OPERAND1,
      S_OPERAND2,
      S_OPERAND3,
      S_CONVERT
   } unit_state_t;

   typedef enum logic [1:0] {
      C_IDLE,
      C_SCALE,
      C_DIVIDE
   } conv_state_t;
endpackage : branch_pkg

// ===== src/stone_converter.sv
// sequential weight-to-stone converter
// assumes start is a one-cycle pulse given only while idle; ACC_W at least 24
`timescale 1ns/1ps
`include "branch_params.svh"
module stone_converter
   import branch_pkg::*;
#(
   parameter int ACC_W = 24
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst,
   // request
   input  wire logic             start,
   input  wire logic [ACC_W-1:0] weight,
   // answer
   output logic                  done_q,
   output logic [ACC_W-1:0]      result_q
);
   localparam int ProdW = ACC_W + 12;
   localparam int LbW   = ProdW - `LB_SHIFT;

   conv_state_t      state_q;
   logic [ACC_W-1:0] weight_q;
   logic [LbW-1:0]   pounds_q;
   logic [6:0]       stone_q;
   logic [ProdW-1:0] product;
   logic [13:0]      display;

   assign product = ProdW'(weight_q) * ProdW'(`LB_RECIP);
   assign display = 14'(stone_q) * 14'(`DISP_SCALE) + 14'(pounds_q[3:0]);

   // scale to whole pounds, then peel off stones of 14 pounds, saturating at 99
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q  <= C_IDLE;
         weight_q <= '0;
         pounds_q <= '0;
         stone_q  <= '0;
         done_q   <= 1'b0;
         result_q <= '0;
      end else begin
         done_q <= 1'b0;
         unique case (state_q)
            C_IDLE: begin
               if (start) begin
                  weight_q <= weight;
                  stone_q  <= '0;
                  state_q  <= C_SCALE;
               end
            end
            C_SCALE: begin
               pounds_q <= product[ProdW-1:`LB_SHIFT];
               state_q  <= C_DIVIDE;
            end
            C_DIVIDE: begin
               if (pounds_q < LbW'(`STONE_LB)) begin
                  result_q <= ACC_W'(display);
                  done_q   <= 1'b1;
                  state_q  <= C_IDLE;
               end else if (stone_q == `STONE_MAX) begin
                  pounds_q <= LbW'(`LB_SAT);
               end else begin
                  pounds_q <= pounds_q - LbW'(`STONE_LB);
                  stone_q  <= stone_q + 7'h01;
               end
            end
         endcase
      end
   end
endmodule : stone_converter

// ===== src/sign_overflow_branch_unit.sv
// execute logic for the sign and overflow conditional jumps and weight_to_stone
// assumes program memory returns pmData in the cycle after pmRead is high,
// and the core holds execution while ready is low; all inputs are on core_clk
`timescale 1ns/1ps
`include "branch_params.svh"
module sign_overflow_branch_unit
   import branch_pkg::*;
#(
   parameter int ACC_W = 24
) (
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst,
   // instruction issue
   input  wire logic              execValid,
   input  wire logic [7:0]        execOpcode,
   input  wire logic [`PC_W-1:0]  execPc,
   input  wire flags_t            flags,
   input  wire logic [ACC_W-1:0]  accuFirst,
   output logic                   ready_q,
   output logic                   illegal_q,
   // program memory operand fetch
   output logic                   pmRead_q,
   output logic [`PC_W-1:0]       pmAddr_q,
   input  wire logic [7:0]        pmData,
   // program counter update
   output pc_update_t             pcUpdate_q,
   // first accumulator write back
   output logic                   accuWe_q,
   output logic [ACC_W-1:0]       accuValue_q
);
   unit_state_t      state_q;
   logic [`PC_W-1:0] basePc_q;
   logic             absForm_q;
   logic             condMet_q;
   logic [7:0]       lowByte_q;
   logic             isJump;
   logic             isStone;
   logic             absForm;
   logic [1:0]       cond;
   logic             condMet;
   logic             convStart_q;
   logic             convDone;
   logic [ACC_W-1:0] convResult;
   logic [`PC_W-1:0] relNext;
   logic [`PC_W-1:0] relTarget;
   logic [`PC_W-1:0] absNext;
   logic [`PC_W-1:0] absTarget;
   logic             accept;

   assign isJump  = execOpcode[7:3] == `OPC_JUMP_GRP;
   assign isStone = execOpcode[7:2] == `OPC_STONE_GRP;
   assign absForm = execOpcode[`OPC_ABS_BIT];
   assign cond    = execOpcode[`OPC_COND_LSB +: 2];
   assign accept  = execValid && (state_q == S_IDLE);

   // condition test on the flags left by the preceding operation
   always_comb begin
      unique case (cond)
         `COND_NEG: condMet = flags.sign == 1'b1;
         `COND_POS: condMet = flags.sign == 1'b0;
         `COND_OVS: condMet = flags.overflow == 1'b1;
         `COND_OVC: condMet = flags.overflow == 1'b0;
      endcase
   end

   // relative offset counts from the instruction after the jump
   assign relNext   = basePc_q + `LEN_REL;
   assign relTarget = relNext + {{(`PC_W-8){pmData[7]}}, pmData};
   assign absNext   = basePc_q + `LEN_ABS;
   assign absTarget = {pmData, lowByte_q};

   // sequencing of the operand bytes and the conversion
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q <= S_IDLE;
      end else begin
         unique case (state_q)
            S_IDLE: begin
               if (accept && isJump) begin
                  state_q <= S_OPERAND1;
               end else if (accept && isStone && execOpcode[1:0] == `ACCU_FIRST) begin
                  state_q <= S_CONVERT;
               end
            end
            S_OPERAND1: state_q <= S_OPERAND2;
            S_OPERAND2: state_q <= absForm_q ? S_OPERAND3 : S_IDLE;
            S_OPERAND3: state_q <= S_IDLE;
            S_CONVERT: begin
               if (convDone) begin
                  state_q <= S_IDLE;
               end
            end
         endcase
      end
   end

   // ready is high in every cycle in which a new instruction is taken
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ready_q <= 1'b1;
      end else if (accept && (isJump || (isStone && execOpcode[1:0] == `ACCU_FIRST))) begin
         ready_q <= 1'b0;
      end else if ((state_q == S_OPERAND2 && !absForm_q) || state_q == S_OPERAND3) begin
         ready_q <= 1'b1;
      end else if (state_q == S_CONVERT && convDone) begin
         ready_q <= 1'b1;
      end
   end

   // unknown opcodes and any other accumulator for the conversion are refused
   always_ff @(posedge core_clk) begin
      if (rst) begin
         illegal_q <= 1'b0;
      end else begin
         illegal_q <= accept && !isJump && !(isStone && execOpcode[1:0] == `ACCU_FIRST);
      end
   end

   // issue context, captured once at accept
   always_ff @(posedge core_clk) begin
      if (rst) begin
         basePc_q  <= '0;
         absForm_q <= 1'b0;
         condMet_q <= 1'b0;
      end else if (accept && isJump) begin
         basePc_q  <= execPc;
         absForm_q <= absForm;
         condMet_q <= condMet;
      end
   end

   // operand reads: first byte right after accept, second pipelined behind it
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pmRead_q <= 1'b0;
         pmAddr_q <= '0;
      end else if (accept && isJump) begin
         pmRead_q <= 1'b1;
         pmAddr_q <= execPc + `OPERAND_OFS1;
      end else if (state_q == S_OPERAND1 && absForm_q) begin
         pmRead_q <= 1'b1;
         pmAddr_q <= basePc_q + `OPERAND_OFS2;
      end else begin
         pmRead_q <= 1'b0;
      end
   end

   // low address byte of the absolute form
   always_ff @(posedge core_clk) begin
      if (rst) begin
         lowByte_q <= 8'h00;
      end else if (state_q == S_OPERAND2 && absForm_q) begin
         lowByte_q <= pmData;
      end
   end

   // program counter update: target when taken, next instruction otherwise
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pcUpdate_q <= '0;
      end else if (state_q == S_OPERAND2 && !absForm_q) begin
         pcUpdate_q.load  <= 1'b1;
         pcUpdate_q.taken <= condMet_q;
         pcUpdate_q.value <= condMet_q ? relTarget : relNext;
      end else if (state_q == S_OPERAND3) begin
         pcUpdate_q.load  <= 1'b1;
         pcUpdate_q.taken <= condMet_q;
         pcUpdate_q.value <= condMet_q ? absTarget : absNext;
      end else begin
         pcUpdate_q.load  <= 1'b0;
         pcUpdate_q.taken <= 1'b0;
      end
   end

   // conversion start pulse and accumulator write back
   always_ff @(posedge core_clk) begin
      if (rst) begin
         convStart_q <= 1'b0;
      end else begin
         convStart_q <= accept && isStone && execOpcode[1:0] == `ACCU_FIRST;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         accuWe_q    <= 1'b0;
         accuValue_q <= '0;
      end else begin
         accuWe_q <= state_q == S_CONVERT && convDone;
         if (state_q == S_CONVERT && convDone) begin
            accuValue_q <= convResult;
         end
      end
   end

   // operand latched at accept so the core may change accuFirst meanwhile
   logic [ACC_W-1:0] weight_q;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         weight_q <= '0;
      end else if (accept && isStone) begin
         weight_q <= accuFirst;
      end
   end

   stone_converter #(
      .ACC_W (ACC_W)
   ) u_stone (
      .core_clk (core_clk),
      .rst      (rst),
      .start    (convStart_q),
      .weight   (weight_q),
      .done_q   (convDone),
      .result_q (convResult)
   );
endmodule : sign_overflow_branch_unit

// ===== dv/sign_overflow_branch_unit_sva.sv
// port checker for the sign/overflow branch unit
// assumes the unit is bound by the statement below and runs on core_clk only
`timescale 1ns/1ps
`include "branch_params.svh"
module sign_overflow_branch_unit_sva
   import branch_pkg::*;
#(
   parameter int ACC_W = 24
) (
   // clock and reset
   input wire logic             core_clk,
   input wire logic             rst,
   // instruction issue
   input wire logic             execValid,
   input wire logic [7:0]       execOpcode,
   input wire logic [`PC_W-1:0] execPc,
   input wire flags_t           flags,
   input wire logic [ACC_W-1:0] accuFirst,
   input wire logic             ready_q,
   input wire logic             illegal_q,
   // fetch, pc update and write back
   input wire logic             pmRead_q,
   input wire logic [`PC_W-1:0] pmAddr_q,
   input wire logic [7:0]       pmData,
   input wire pc_update_t       pcUpdate_q,
   input wire logic             accuWe_q,
   input wire logic [ACC_W-1:0] accuValue_q
);
   logic             take;
   logic             jump;
   logic             condQ;
   logic             relQ;
   logic [`PC_W-1:0] pcQ;
   assign take = execValid && ready_q;
   assign jump = take && execOpcode[7:3] == 5'h09;
   // condition, form and pc of the accepted jump
   always_ff @(posedge core_clk) begin
      if (jump) begin
         condQ <= execOpcode[2] ? execOpcode[1] ^ flags.overflow : execOpcode[1] ^ flags.sign;
         relQ  <= !execOpcode[0];
         pcQ   <= execPc;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_rel_timing: assert property (
      jump && !execOpcode[0] |=> pmRead_q && pmAddr_q == pcQ + 16'h0001 && !pcUpdate_q.load
      ##1 !pmRead_q && !pcUpdate_q.load ##1 pcUpdate_q.load && ready_q)
      else $error("relative jump fetch or load timing wrong");
   a_abs_timing: assert property (
      jump && execOpcode[0] |=> pmRead_q && pmAddr_q == pcQ + 16'h0001 ##1 pmRead_q && pmAddr_q == pcQ + 16'h0002
      ##1 !pcUpdate_q.load ##1 pcUpdate_q.load && ready_q)
      else $error("absolute jump fetch or load timing wrong");
   a_taken_cond: assert property (
      pcUpdate_q.load |-> pcUpdate_q.taken == condQ) else $error("taken differs from flag condition");
   a_rel_target: assert property (
      pcUpdate_q.load && pcUpdate_q.taken && relQ |->
      pcUpdate_q.value == pcQ + 16'h0002 + {{8{$past(pmData[7])}}, $past(pmData)})
      else $error("relative target wrong");
   a_abs_target: assert property (
      pcUpdate_q.load && pcUpdate_q.taken && !relQ |-> pcUpdate_q.value == {$past(pmData), $past(pmData, 2)})
      else $error("absolute target wrong");
   a_fall_through: assert property (
      pcUpdate_q.load && !pcUpdate_q.taken |-> pcUpdate_q.value == pcQ + (relQ ? 16'h0002 : 16'h0003))
      else $error("fall-through address wrong");
   a_load_pulse: assert property (
      pcUpdate_q.load |=> !pcUpdate_q.load) else $error("load longer than one cycle");
   a_stone_accu: assert property (
      take && execOpcode[7:2] == 6'h14 && execOpcode[1:0] != 2'h0 |=> illegal_q && ready_q && !accuWe_q)
      else $error("other accumulator accepted for conversion");
   a_stone_write: assert property (
      take && execOpcode == 8'h50 |=> !ready_q ##[2:110] accuWe_q && ready_q)
      else $error("conversion write back missing");
   cover property (pcUpdate_q.load && pcUpdate_q.taken && relQ);
   cover property (pcUpdate_q.load && pcUpdate_q.taken && !relQ);
   cover property (accuWe_q);
   cover property (illegal_q);
endmodule : sign_overflow_branch_unit_sva

bind sign_overflow_branch_unit sign_overflow_branch_unit_sva #(.ACC_W(ACC_W)) u_sva (
   .core_clk(core_clk), .rst(rst), .execValid(execValid), .execOpcode(execOpcode), .execPc(execPc),
   .flags(flags), .accuFirst(accuFirst), .ready_q(ready_q), .illegal_q(illegal_q), .pmRead_q(pmRead_q),
   .pmAddr_q(pmAddr_q), .pmData(pmData), .pcUpdate_q(pcUpdate_q), .accuWe_q(accuWe_q), .accuValue_q(accuValue_q));

// ===== dv/tb_sign_overflow_branch_unit.sv
// self-checking bench for the sign/overflow branch unit
// assumes a byte memory model answering one cycle after each fetch
`timescale 1ns/1ps
module tb_sign_overflow_branch_unit;
   import branch_pkg::*;
   logic             core_clk = 1'b0;
   logic             rst = 1'b1;
   logic             execValid = 1'b0;
   logic [7:0]       execOpcode = 8'h00;
   logic [15:0]      execPc = 16'h0000;
   flags_t           flags = 4'h0;
   logic [23:0]      accuFirst = 24'h000000;
   logic [7:0]       pmData = 8'h00;
   logic             ready_q, illegal_q, pmRead_q, accuWe_q, rd;
   logic [15:0]      pmAddr_q;
   logic [7:0]       ad;
   pc_update_t       pcUpdate_q;
   logic [23:0]      accuValue_q;
   logic [7:0]       mem [0:255];
   int               miscompares = 0;
   int               samples_checked = 0;
   int               cyc = 0;
   always #5 core_clk = ~core_clk;
   sign_overflow_branch_unit #(.ACC_W(24)) DUT (
      .core_clk(core_clk), .rst(rst), .execValid(execValid), .execOpcode(execOpcode), .execPc(execPc),
      .flags(flags), .accuFirst(accuFirst), .ready_q(ready_q), .illegal_q(illegal_q), .pmRead_q(pmRead_q),
      .pmAddr_q(pmAddr_q), .pmData(pmData), .pcUpdate_q(pcUpdate_q), .accuWe_q(accuWe_q),
      .accuValue_q(accuValue_q));
   // memory answers in the cycle after a fetch, otherwise shows a changing pattern
   always @(posedge core_clk) begin
      rd = pmRead_q;
      ad = pmAddr_q[7:0];
      #1 pmData = rd ? mem[ad] : ~pmData;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         results();
      end
   end
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %0h seen %0h", name, exp, got);
      end
   endtask : chk
   task automatic jump(input logic [7:0] op, input logic [15:0] pc, input flags_t f);
      logic        cond;
      logic [15:0] exp;
      int          n;
      cond = op[2] ? op[1] ^ f.overflow : op[1] ^ f.sign;
      if (!cond) exp = pc + (op[0] ? 16'h0003 : 16'h0002);
      else if (op[0]) exp = {mem[pc[7:0] + 8'h02], mem[pc[7:0] + 8'h01]};
      else exp = pc + 16'h0002 + {{8{mem[pc[7:0] + 8'h01][7]}}, mem[pc[7:0] + 8'h01]};
      execValid = 1'b1;
      execOpcode = op;
      execPc = pc;
      flags = f;
      @(posedge core_clk);
      #1 execValid = 1'b0;
      n = 1;
      while (pcUpdate_q.load !== 1'b1 && n < 10) begin
         @(posedge core_clk);
         #1 n++;
      end
      chk("cycles", op[0] ? 4 : 3, n);
      chk("taken", cond, pcUpdate_q.taken);
      chk("target", exp, pcUpdate_q.value);
      chk("ready", 1, ready_q);
   endtask : jump
   task automatic stone(input logic [23:0] w);
      longint lb;
      longint st;
      int     n;
      lb = (longint'(w) * 3699) >> 24;
      st = lb / 14;
      lb = lb % 14;
      if (st > 99) begin
         st = 99;
         lb = 13;
      end
      execValid = 1'b1;
      execOpcode = 8'h50;
      accuFirst = w;
      @(posedge core_clk);
      #1 execValid = 1'b0;
      n = 1;
      while (accuWe_q !== 1'b1 && n < 200) begin
         @(posedge core_clk);
         #1 n++;
      end
      chk("accuValue", 32'(st * 100 + lb), accuValue_q);
      chk("ready", 1, ready_q);
      $display("test weight_to_stone %0d done", w);
   endtask : stone
   task automatic bad(input logic [7:0] op);
      execValid = 1'b1;
      execOpcode = op;
      @(posedge core_clk);
      #1 execValid = 1'b0;
      chk("illegal", 1, illegal_q);
      chk("load", 0, pcUpdate_q.load);
      chk("write", 0, accuWe_q);
      @(posedge core_clk);
      #1 $display("test refused opcode %0h done", op);
   endtask : bad
   task automatic results;
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : results
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'(i * 37 + 129);
      repeat (10) @(posedge core_clk);
      #1 rst = 1'b0;
      // back to back jumps, each code with its flag at both levels, carry and zero opposite
      for (int i = 0; i < 16; i++) jump(8'h48 + 8'(i % 8), 16'h0010 + 16'(i * 5), i < 8 ? 4'h3 : 4'hC);
      $display("test conditional jumps done");
      stone(24'h000000);
      stone(24'h00B12F);
      stone(24'h09B096);
      stone(24'hFFFFFF);
      bad(8'h51);
      bad(8'h53);
      bad(8'h00);
      results();
   end
endmodule : tb_sign_overflow_branch_unit
